// file: logic/psr_pkg.sv
// Constants and carrier types for the processor supervisor reset block.
// Assumes a single free-running 25 MHz core clock.
package psr_pkg;

  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned TICK_US = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;

  localparam int unsigned DEBOUNCE_MS = 1;
  localparam int unsigned HOLD_MS = 250;
  localparam int unsigned WDOG_SHORT_MS = 150;
  localparam int unsigned WDOG_MID_MS = 600;
  localparam int unsigned WDOG_LONG_MS = 1200;

  localparam int unsigned TICKS_PER_MS = 1000 / TICK_US;
  localparam int unsigned DEBOUNCE_TICKS = DEBOUNCE_MS * TICKS_PER_MS;
  localparam int unsigned HOLD_TICKS = HOLD_MS * TICKS_PER_MS;
  localparam int unsigned WDOG_SHORT_TICKS = WDOG_SHORT_MS * TICKS_PER_MS;
  localparam int unsigned WDOG_MID_TICKS = WDOG_MID_MS * TICKS_PER_MS;
  localparam int unsigned WDOG_LONG_TICKS = WDOG_LONG_MS * TICKS_PER_MS;

  localparam int unsigned CNT_W = 16;

  typedef enum logic [1:0] {
    PSR_TD_LOW = 2'b00,
    PSR_TD_OPEN = 2'b01,
    PSR_TD_HIGH = 2'b10
  } psr_td_t;

  typedef enum logic [1:0] {
    PSR_HOLD = 2'b00,
    PSR_RUN = 2'b01
  } psr_state_t;

  typedef struct packed {
    logic reset_high;
    logic reset_low_oe;
  } psr_reset_out_t;

endpackage : psr_pkg

// file: logic/psr_tick_counter.sv
// Prescaler producing a one-cycle tick every TICK_CYCLES core clocks.
// Assumes core_clk free-running and rst_n asynchronous active low.
`timescale 1ns/1ps
module psr_tick_counter
  import psr_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  output logic tick
);

  logic [15:0] div_reg;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_reg <= 16'h0000;
      tick <= 1'b0;
    end
    else if (div_reg == 16'(CYCLES - 1))
    begin
      div_reg <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      div_reg <= div_reg + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule : psr_tick_counter

// file: logic/psr_supervisor.sv
// Processor supervisor: debounced manual reset, supply-low input, watchdog and hold timer.
// Assumes strap and pin inputs are asynchronous; the supply comparator lives outside.
`timescale 1ns/1ps

// Functional notes
// RULE1: Manual reset low pulses shorter than one millisecond are discarded.
// RULE2: The driver of the manual reset keeps it low at least 20 ms to guarantee a reset.
// RULE3: Manual reset low for the push-button delay drives both reset outputs active.
// RULE4: After manual reset returns high the outputs stay active at least 250 ms.
// RULE5: The timeout strap picks 150 ms, 600 ms or 1.2 s as the watchdog period.
// RULE6: The tolerance strap picks the supply-low threshold used by the comparator.
// RULE7: Supply low or power-up holds reset until the supply is good for 250 ms unbroken.
// RULE8: Two reset outputs change together: one driven high, one open-drain low.
// RULE9: Reset is asserted when the strobe is not strobed within the period.
// RULE10: A strobe falling edge restarts the watchdog from the full period.
// RULE11: The watchdog counts only while both reset outputs are inactive.
// RULE12: On watchdog expiry both outputs are active for at least 250 ms.
// RULE13: All intervals are counted by a prescaled tick from one clock, one parameter each.
// RULE14: The synchronised supply-low level is ORed with the other causes before the hold.
module psr_supervisor
  import psr_pkg::*;
#(
  parameter int unsigned DEBOUNCE_T = DEBOUNCE_TICKS,
  parameter int unsigned HOLD_T = HOLD_TICKS,
  parameter int unsigned WD_SHORT_T = WDOG_SHORT_TICKS,
  parameter int unsigned WD_MID_T = WDOG_MID_TICKS,
  parameter int unsigned WD_LONG_T = WDOG_LONG_TICKS,
  parameter int unsigned TICK_T = TICK_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic manual_reset_n,
  input wire logic watchdog_strobe,
  input wire logic supply_low,
  input wire logic [1:0] timeout_select,
  input wire logic tolerance_select,
  output logic tolerance_sel_out,
  output logic reset_high,
  output logic reset_low_out,
  output logic reset_low_oe
);

  logic tick;
  logic [2:0] mr_sync_reg, st_sync_reg, sl_sync_reg, tol_sync_reg;
  logic [1:0] td_s1_reg, td_s2_reg;
  logic mr_low_reg;
  logic st_prev_reg;
  logic [CNT_W-1:0] deb_reg, hold_reg, wd_reg;
  logic cause;
  logic wd_expire_reg;
  logic strobe_fall;
  psr_state_t state_reg;

  function automatic logic [CNT_W-1:0] period_of(input logic [1:0] sel);
    unique case (sel)
      PSR_TD_LOW: period_of = CNT_W'(WD_SHORT_T);
      PSR_TD_HIGH: period_of = CNT_W'(WD_LONG_T);
      default: period_of = CNT_W'(WD_MID_T);
    endcase
  endfunction : period_of

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  // RULE13: one prescaled tick
  psr_tick_counter #(.CYCLES(TICK_T)) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mr_sync_reg <= 3'h7;
      st_sync_reg <= 3'h7;
      sl_sync_reg <= 3'h7;
      tol_sync_reg <= 3'h0;
      td_s1_reg <= 2'h1;
      td_s2_reg <= 2'h1;
    end
    else
    begin
      mr_sync_reg <= {mr_sync_reg[1:0], manual_reset_n};
      st_sync_reg <= {st_sync_reg[1:0], watchdog_strobe};
      sl_sync_reg <= {sl_sync_reg[1:0], supply_low};
      tol_sync_reg <= {tol_sync_reg[1:0], tolerance_select};
      td_s1_reg <= timeout_select;
      td_s2_reg <= td_s1_reg;
    end
  end

  // RULE6: threshold choice passed to comparator
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tolerance_sel_out <= 1'b0;
    else
      tolerance_sel_out <= tol_sync_reg[1];
  end

  // ----------------------------------------------------------------
  // Manual reset debounce
  // ----------------------------------------------------------------
  // RULE1: low must persist for the debounce time
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      deb_reg <= '0;
      mr_low_reg <= 1'b0;
    end
    else if (mr_sync_reg[1])
    begin
      deb_reg <= '0;
      mr_low_reg <= 1'b0;
    end
    // RULE3: delay met, cause asserted
    else if (tick)
    begin
      if (deb_reg >= CNT_W'(DEBOUNCE_T))
        mr_low_reg <= 1'b1;
      else
        deb_reg <= deb_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Cause merge and hold timer
  // ----------------------------------------------------------------
  // RULE14: all causes ORed
  assign cause = mr_low_reg | sl_sync_reg[1] | wd_expire_reg;

  // RULE4: hold restarts while any cause is present
  // RULE7: supply must stay good for the full hold
  // RULE12: expiry followed by full hold
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_reg <= '0;
      state_reg <= PSR_HOLD;
    end
    else if (cause)
    begin
      hold_reg <= '0;
      state_reg <= PSR_HOLD;
    end
    else if (state_reg == PSR_HOLD && tick)
    begin
      if (hold_reg >= CNT_W'(HOLD_T - 1))
        state_reg <= PSR_RUN;
      else
        hold_reg <= hold_reg + 1'b1;
    end
  end

  // RULE8: outputs change together
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reset_high <= 1'b1;
      reset_low_oe <= 1'b1;
      reset_low_out <= 1'b0;
    end
    else
    begin
      reset_high <= (state_reg == PSR_HOLD) || cause;
      reset_low_oe <= (state_reg == PSR_HOLD) || cause;
      reset_low_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  assign strobe_fall = st_prev_reg & ~st_sync_reg[2];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_prev_reg <= 1'b1;
    else
      st_prev_reg <= st_sync_reg[2];
  end

  // RULE11: count only when outputs inactive
  // RULE5: reload from strap period
  // RULE10: strobe edge reloads
  // RULE9: expiry raises a cause
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wd_reg <= '0;
      wd_expire_reg <= 1'b0;
    end
    else if (reset_high || state_reg == PSR_HOLD)
    begin
      wd_reg <= period_of(td_s2_reg);
      wd_expire_reg <= 1'b0;
    end
    else if (strobe_fall)
      wd_reg <= period_of(td_s2_reg);
    else if (tick)
    begin
      if (wd_reg <= CNT_W'(1))
        wd_expire_reg <= 1'b1;
      else
        wd_reg <= wd_reg - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // RULE8: outputs agree
  a_outputs_agree: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE8
    reset_high == reset_low_oe && !reset_low_out)
    else $error("reset outputs disagree");

  // RULE14: any cause forces reset next cycle
  a_cause_resets: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE14
    cause |=> reset_high)
    else $error("cause did not assert reset");

  // RULE7: supply low holds reset
  a_supply_holds: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE7
    sl_sync_reg[1] |=> reset_high)
    else $error("supply low without reset");

  // RULE3: debounced manual reset asserts reset
  a_manual_resets: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE3
    $rose(mr_low_reg) |=> reset_high)
    else $error("manual reset ignored");

  // RULE1: no debounced low while input high
  a_debounce_short: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE1
    mr_sync_reg[1] |=> !mr_low_reg)
    else $error("debounce passed a high input");

  // RULE4: release only from a full hold count
  a_hold_min: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE4
    $fell(reset_high) |-> $past(hold_reg, 2) >= CNT_W'(HOLD_T - 1))
    else $error("reset released early");

  // RULE11: watchdog idle during reset
  a_wd_idle: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE11
    reset_high |=> !wd_expire_reg)
    else $error("watchdog ran during reset");

  // RULE10: strobe edge reloads period
  a_strobe_reload: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE10
    strobe_fall && !reset_high && state_reg == PSR_RUN |=> wd_reg == period_of($past(td_s2_reg)))
    else $error("strobe did not reload watchdog");

  // RULE9: expiry asserts reset
  a_wd_expiry: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE9
    $rose(wd_expire_reg) |=> reset_high ##1 reset_high)
    else $error("expiry did not reset");

  c_manual: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(mr_low_reg));
  c_expire: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(wd_expire_reg));
  c_release: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(reset_high));

endmodule : psr_supervisor

// file: sim/psr_cpu_model.sv
// Processor model that receives the supervisor reset and toggles the watchdog strobe.
// Assumes the bench supplies the core clock and the reset level as seen by the processor.
`timescale 1ns/1ps
module psr_cpu_model
(
  input wire logic core_clk,
  input wire logic reset_high,
  input wire logic strobe_on,
  input wire logic [7:0] gap,
  output logic watchdog_strobe
);
  logic [7:0] cnt_reg;

  initial
  begin
    watchdog_strobe = 1'b1;
    cnt_reg = 8'h00;
  end

  always @(negedge core_clk)
  begin
    if (reset_high || !strobe_on)
    begin
      cnt_reg <= 8'h00;
    end
    else if (cnt_reg == gap)
    begin
      cnt_reg <= 8'h00;
      watchdog_strobe <= ~watchdog_strobe;
    end
    else
    begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule : psr_cpu_model

// file: sim/test_processor_supervisor_reset.sv
// Self-checking bench for the supervisor with shortened interval parameters.
// Assumes one tick is 4 core clocks; all inputs change on the falling edge.
`timescale 1ns/1ps
module test_processor_supervisor_reset;
  import psr_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic manual_reset_n = 1'b1;
  logic supply_low = 1'b0;
  logic [1:0] timeout_select = 2'h0;
  logic tolerance_select = 1'b1;
  logic strobe_on = 1'b1;
  logic [7:0] gap = 8'h06;
  logic watchdog_strobe;
  logic tolerance_sel_out;
  logic reset_high;
  logic reset_low_out;
  logic reset_low_oe;
  logic reset_low_n;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;

  // The open-drain reset line has a pull-up on the processor side.
  assign reset_low_n = reset_low_oe ? reset_low_out : 1'b1;

  psr_supervisor #(.HOLD_T(5), .WD_SHORT_T(8), .WD_MID_T(12),
    .WD_LONG_T(16), .TICK_T(4)) psr_supervisor_inst (
    .core_clk(core_clk), .rst_n(rst_n), .manual_reset_n(manual_reset_n),
    .watchdog_strobe(watchdog_strobe), .supply_low(supply_low),
    .timeout_select(timeout_select), .tolerance_select(tolerance_select),
    .tolerance_sel_out(tolerance_sel_out), .reset_high(reset_high),
    .reset_low_out(reset_low_out), .reset_low_oe(reset_low_oe));

  psr_cpu_model psr_cpu_model_inst (.core_clk(core_clk), .reset_high(reset_high),
    .strobe_on(strobe_on), .gap(gap), .watchdog_strobe(watchdog_strobe));

  initial
  begin
    forever #20 core_clk = ~core_clk;
  end

  task end_of_test;
    $display("checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task check(input logic seen, input logic exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t saw %b expected %b", $time, seen, exp);
    end
  endtask : check

  task cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc

  task wait_rst(input logic v, output int k);
    k = 0;
    while (reset_high !== v && k < 200)
    begin
      @(negedge core_clk);
      k++;
    end
  endtask : wait_rst

  always @(negedge core_clk)
  begin
    cycles++;
    if (rst_n)
      check(reset_low_n, ~reset_high);
    if (cycles == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task t_powerup;
    cyc(12);
    check(reset_high, 1'b1);
    wait_rst(1'b0, n);
    check(n <= 30, 1'b1);
    check(tolerance_sel_out, 1'b1);
    tolerance_select = 1'b0;
    cyc(4);
    check(tolerance_sel_out, 1'b0);
    tolerance_select = 1'b1;
    cyc(4);
  endtask : t_powerup

  task t_supply;
    supply_low = 1'b1;
    cyc(4);
    check(reset_high, 1'b1);
    cyc(30);
    check(reset_high, 1'b1);
    supply_low = 1'b0;
    cyc(14);
    check(reset_high, 1'b1);
    wait_rst(1'b0, n);
    check(n <= 30, 1'b1);
  endtask : t_supply

  task t_manual;
    manual_reset_n = 1'b0;
    cyc(30);
    manual_reset_n = 1'b1;
    cyc(20);
    check(reset_high, 1'b0);
    // held low for the scaled guarantee time.
    manual_reset_n = 1'b0;
    wait_rst(1'b1, n);
    check(n >= DEBOUNCE_TICKS * 4, 1'b1);
    check(n <= (DEBOUNCE_TICKS + 3) * 4, 1'b1);
    cyc(20 * TICKS_PER_MS * 4);
    manual_reset_n = 1'b1;
    cyc(14);
    check(reset_high, 1'b1);
    wait_rst(1'b0, n);
    check(n <= 30, 1'b1);
  endtask : t_manual

  task t_watchdog(input logic [1:0] sel, input int per);
    timeout_select = sel;
    strobe_on = 1'b0;
    supply_low = 1'b1;
    cyc(4);
    supply_low = 1'b0;
    wait_rst(1'b0, n);
    wait_rst(1'b1, n);
    check(n >= per * 4 - 8 && n <= per * 4 + 8, 1'b1);
    cyc(12);
    check(reset_high, 1'b1);
    strobe_on = 1'b1;
    wait_rst(1'b0, n);
    check(n <= 30, 1'b1);
  endtask : t_watchdog

  task t_strobe;
    timeout_select = 2'h0;
    strobe_on = 1'b1;
    gap = 8'h0c;
    cyc(150);
    check(reset_high, 1'b0);
    gap = 8'h06;
  endtask : t_strobe

  initial
  begin
    cyc(3);
    rst_n = 1'b1;
    t_powerup();
    t_supply();
    t_manual();
    t_watchdog(2'h0, 8);
    t_watchdog(2'h1, 12);
    t_watchdog(2'h2, 16);
    t_watchdog(2'h3, 12);
    t_strobe();
    end_of_test();
  end
endmodule : test_processor_supervisor_reset
